/* File: logic/rss_pin_sync.sv */
`timescale 1ns/10ps
module rss_pin_sync #(
    parameter int unsigned     W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic         clk_i,    // system clock
    input  wire logic         rst_n_i,  // synchronised reset
    input  wire logic [W-1:0] d_i,      // asynchronous pin levels
    output logic      [W-1:0] q_o       // filtered levels
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_d;

    // a bit changes only once stages two and three agree
    assign q_d = (s2_q & s3_q) | (q_o & (s2_q ^ s3_q));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q_o  <= RST_VAL;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_o  <= q_d;
        end
    end
endmodule

/* File: logic/rss_pkg.sv */
package rss_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned RSS_CLK_MHZ            = 50;
    localparam int unsigned RSS_PHASE_TIME_NS      = 1000;
    localparam int unsigned RSS_PHASE_CYCLES       = (RSS_PHASE_TIME_NS * RSS_CLK_MHZ + 999) / 1000;
    localparam int unsigned RSS_WDG_FACTORY_MS     = 1500;
    localparam logic [31:0] RSS_WDG_FACTORY_CYCLES =
        32'(RSS_WDG_FACTORY_MS * RSS_CLK_MHZ * 1000);
    localparam int unsigned RSS_RST_SYNC_STAGES    = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam int unsigned RSS_AW        = 5;
    localparam logic [4:0]  RSS_OFS_CTRL  = 5'h00;
    localparam logic [4:0]  RSS_OFS_WDG   = 5'h04;
    localparam logic [4:0]  RSS_OFS_ERR   = 5'h08;
    localparam logic [4:0]  RSS_OFS_MASK  = 5'h0C;
    localparam logic [4:0]  RSS_OFS_STATE = 5'h10;

    // control register fields
    localparam int unsigned RSS_CTRL_SHORT_SEL  = 0;
    localparam int unsigned RSS_CTRL_ONLINE_GO  = 1;
    localparam int unsigned RSS_CTRL_PLL_EN     = 2;
    localparam int unsigned RSS_CTRL_OFFLINE_EN = 3;
    localparam int unsigned RSS_CTRL_W          = 4;
    localparam logic [3:0]  RSS_CTRL_RST        = 4'h0;

    // error status / mask layout
    localparam int unsigned RSS_ERR_W    = 3;
    localparam logic [2:0]  RSS_ERR_RST  = 3'h0;
    localparam logic [2:0]  RSS_MASK_RST = 3'h0;

    // state register: bits 2:0 state code, bit 3 in reset sequence
    localparam int unsigned RSS_STATE_INRST = 3;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic pll_unlock;
        logic wdg_timeout;
        logic hw_abort;
    } rss_err_type;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } rss_bus_req_type;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_PH1,
        ST_PH2,
        ST_PH3_DEST,
        ST_PH3_FUNC,
        ST_OFFLINE,
        ST_ONLINE
    } rss_state_type;

endpackage

/* File: logic/rss_sequencer.sv */
// Functional notes
// - short-select bit set makes external pin reset take the short sequence
// - self-test wait is bounded by the programmed watchdog end count
// - hardware abort of online self-test sets the abort flag
// - watchdog expiry before self-test completion sets the timeout flag
// - pll lock loss during online self-test with pll enabled sets unlock flag
// - watchdog expiry in reset sequence issues device reset and exits sequence
// - watchdog interval defaults to 1.5 s, replaceable from config record
// - long external reset enters the sequence at phase one
// - destructive reset enters at the phase three destructive point
// - functional reset enters at the phase three functional point
// - low-voltage detect on any supply enters the reset sequence
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module rss_sequencer #(
    parameter int unsigned N_LVD       = 3,
    parameter logic [31:0] WDG_CYCLES  = rss_pkg::RSS_WDG_FACTORY_CYCLES,
    parameter int unsigned PHASE_CYC   = rss_pkg::RSS_PHASE_CYCLES
) (
    input  wire logic              clk_i,                 // 50 MHz system clock
    input  wire logic              rst_n_i,               // async reset, active low
    input  wire logic              avs_read,              // avalon read
    input  wire logic              avs_write,             // avalon write
    input  wire logic [4:0]        avs_address,           // byte address
    input  wire logic [3:0]        avs_byteenable,        // write lanes
    input  wire logic [31:0]       avs_writedata,         // write data
    output logic      [31:0]       avs_readdata,          // read data, registered
    output logic                   avs_waitrequest,       // stall
    input  wire logic              power_on_reset_in_n_i, // supervisor pin, low active
    input  wire logic              ext_reset_n_i,         // external reset pin
    input  wire logic [N_LVD-1:0]  lvd_i,                 // low-voltage detects
    input  wire logic              pll_locked_i,          // pll lock status
    input  wire logic              dest_req_i,            // destructive request
    input  wire logic              func_req_i,            // functional request
    input  wire logic              selftest_done_i,       // self-test finished
    input  wire logic              cfg_load_i,            // config record valid pulse
    input  wire logic [31:0]       cfg_wdg_value_i,       // config record interval
    output logic                   device_reset_o,        // one-cycle device reset
    output logic                   in_reset_o,            // reset sequence active
    output logic                   online_run_o,          // online self-test running
    output logic                   offline_run_o,         // offline self-test running
    output logic                   selftest_abort_o,      // one-cycle abort pulse
    output logic                   irq_o                  // level interrupt
);
    ////////////////////////////////////////////////////////////////////////////////
    // reset release
    logic [rss_pkg::RSS_RST_SYNC_STAGES-1:0] rst_sh_q;
    logic                                    rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sh_q <= '0;
        end else begin
            rst_sh_q <= {rst_sh_q[rss_pkg::RSS_RST_SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign rst_n = rst_sh_q[rss_pkg::RSS_RST_SYNC_STAGES-1];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // pins
    logic [N_LVD+2:0] pin_raw;
    logic [N_LVD+2:0] pin_s;
    logic             por_act;
    logic             ext_act;
    logic             lvd_act;
    logic             pll_lock;

    assign pin_raw = {pll_locked_i, power_on_reset_in_n_i, ext_reset_n_i, lvd_i};

    rss_pin_sync #(
        .W       (N_LVD + 3),
        .RST_VAL ({3'h7, {N_LVD{1'b0}}})
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .d_i     (pin_raw),
        .q_o     (pin_s)
    );

    assign lvd_act  = |pin_s[N_LVD-1:0];
    assign ext_act  = ~pin_s[N_LVD];
    assign por_act  = ~pin_s[N_LVD+1];
    assign pll_lock = pin_s[N_LVD+2];

    ////////////////////////////////////////////////////////////////////////////////
    // registers and bus
    rss_pkg::rss_bus_req_type  req;
    rss_pkg::rss_state_type    state_q;
    rss_pkg::rss_state_type    state_d;
    rss_pkg::rss_err_type      err_q;
    rss_pkg::rss_err_type      err_set;
    logic [rss_pkg::RSS_CTRL_W-1:0] ctrl_q;
    logic [31:0]               wdg_q;
    logic [2:0]                mask_q;
    logic                      ack_q;
    logic                      wr_fire;
    logic [31:0]               wmask;
    logic [31:0]               rd_mux;
    logic                      wr_ctrl;
    logic                      wr_wdg;
    logic                      wr_err;
    logic                      wr_mask;
    logic                      short_sel;
    logic                      online_go;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    assign req             = '{rd: avs_read, wr: avs_write, addr: avs_address,
                               be: avs_byteenable, wdata: avs_writedata};
    // one wait cycle on every access, answer on the second edge
    assign avs_waitrequest = (req.rd | req.wr) & ~ack_q;
    assign wr_fire         = req.wr & ack_q;
    assign wmask           = lane_mask(req.be);
    assign wr_ctrl         = wr_fire && (req.addr == rss_pkg::RSS_OFS_CTRL);
    assign wr_wdg          = wr_fire && (req.addr == rss_pkg::RSS_OFS_WDG);
    assign wr_err          = wr_fire && (req.addr == rss_pkg::RSS_OFS_ERR);
    assign wr_mask         = wr_fire && (req.addr == rss_pkg::RSS_OFS_MASK);
    assign short_sel       = ctrl_q[rss_pkg::RSS_CTRL_SHORT_SEL];
    assign online_go       = wr_ctrl && wmask[rss_pkg::RSS_CTRL_ONLINE_GO]
                             && req.wdata[rss_pkg::RSS_CTRL_ONLINE_GO];

    assign rd_mux = (req.addr == rss_pkg::RSS_OFS_CTRL)  ? 32'(ctrl_q) :
                    (req.addr == rss_pkg::RSS_OFS_WDG)   ? wdg_q :
                    (req.addr == rss_pkg::RSS_OFS_ERR)   ? 32'(err_q) :
                    (req.addr == rss_pkg::RSS_OFS_MASK)  ? 32'(mask_q) :
                    (req.addr == rss_pkg::RSS_OFS_STATE) ? 32'({in_reset_o, state_q}) :
                    32'h0000_0000;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack_q        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= (req.rd | req.wr) & ~ack_q;
            if (req.rd && !ack_q) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // go bit is a pulse; it never reads back as one
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= rss_pkg::RSS_CTRL_RST;
            mask_q <= rss_pkg::RSS_MASK_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= 4'(merge(32'(ctrl_q), req.wdata, wmask)) & 4'hD;
            end
            if (wr_mask) begin
                mask_q <= 3'(merge(32'(mask_q), req.wdata, wmask));
            end
        end
    end

    // interval comes up at the factory value; a record load or software replaces it
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wdg_q <= WDG_CYCLES;
        end else if (wr_wdg) begin
            wdg_q <= merge(wdg_q, req.wdata, wmask);
        end else if (cfg_load_i) begin
            wdg_q <= cfg_wdg_value_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog and phase timer
    logic [31:0] wdg_cnt_q;
    logic [15:0] ph_cnt_q;
    logic        wdg_exp;
    logic        ph_done;
    logic        in_seq;
    logic        busy;

    assign in_seq  = (state_q != rss_pkg::ST_RUN) && (state_q != rss_pkg::ST_ONLINE);
    assign busy    = state_q != rss_pkg::ST_RUN;
    // a zero end count expires in the first busy cycle
    assign wdg_exp = busy && (wdg_cnt_q >= wdg_q);
    assign ph_done = ph_cnt_q == 16'(PHASE_CYC - 1);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wdg_cnt_q <= 32'h0000_0000;
            ph_cnt_q  <= 16'h0000;
        end else begin
            wdg_cnt_q <= (!busy || wdg_exp) ? 32'h0000_0000 : wdg_cnt_q + 32'h0000_0001;
            ph_cnt_q  <= (state_d != state_q || ph_done) ? 16'h0000 : ph_cnt_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // entry decode, watchdog expiry has the last word
    logic ent_ph1;
    logic ent_dest;
    logic ent_func;
    logic hold_req;

    assign ent_ph1  = por_act | lvd_act | (ext_act & ~short_sel);
    assign ent_dest = dest_req_i & ~ent_ph1;
    assign ent_func = ~ent_ph1 & ~dest_req_i & (func_req_i | (ext_act & short_sel));
    assign hold_req = ent_ph1 | ent_dest | ent_func;

    always_comb begin
        state_d = state_q;
        if (wdg_exp) begin
            state_d = rss_pkg::ST_RUN;
        end else if (ent_ph1) begin
            state_d = rss_pkg::ST_PH1;
        end else if (ent_dest) begin
            state_d = rss_pkg::ST_PH3_DEST;
        end else if (ent_func) begin
            state_d = rss_pkg::ST_PH3_FUNC;
        end else begin
            unique case (state_q)
                rss_pkg::ST_RUN: begin
                    if (online_go) begin
                        state_d = rss_pkg::ST_ONLINE;
                    end
                end
                rss_pkg::ST_PH1: begin
                    if (ph_done) begin
                        state_d = rss_pkg::ST_PH2;
                    end
                end
                rss_pkg::ST_PH2: begin
                    if (ph_done) begin
                        state_d = rss_pkg::ST_PH3_DEST;
                    end
                end
                rss_pkg::ST_PH3_DEST: begin
                    if (ph_done) begin
                        state_d = rss_pkg::ST_PH3_FUNC;
                    end
                end
                rss_pkg::ST_PH3_FUNC: begin
                    if (ph_done) begin
                        state_d = ctrl_q[rss_pkg::RSS_CTRL_OFFLINE_EN] ?
                                  rss_pkg::ST_OFFLINE : rss_pkg::ST_RUN;
                    end
                end
                rss_pkg::ST_OFFLINE,
                rss_pkg::ST_ONLINE: begin
                    if (selftest_done_i) begin
                        state_d = rss_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_d = rss_pkg::ST_PH1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // error flags, set beats a write-one-to-clear in the same cycle
    logic self_run;
    logic abort_now;

    assign self_run  = (state_q == rss_pkg::ST_ONLINE) || (state_q == rss_pkg::ST_OFFLINE);
    assign abort_now = (state_q == rss_pkg::ST_ONLINE) && !wdg_exp && hold_req;
    assign err_set   = '{pll_unlock:  (state_q == rss_pkg::ST_ONLINE)
                                      && ctrl_q[rss_pkg::RSS_CTRL_PLL_EN] && !pll_lock,
                         wdg_timeout: self_run && wdg_exp,
                         hw_abort:    abort_now};

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            err_q            <= rss_pkg::RSS_ERR_RST;
            state_q          <= rss_pkg::ST_PH1;
            device_reset_o   <= 1'b0;
            selftest_abort_o <= 1'b0;
        end else begin
            err_q            <= (err_q & ~(wr_err ? req.wdata[2:0] & wmask[2:0] : 3'h0))
                                | err_set;
            state_q          <= state_d;
            device_reset_o   <= wdg_exp;
            selftest_abort_o <= abort_now;
        end
    end

    assign in_reset_o    = in_seq;
    assign online_run_o  = state_q == rss_pkg::ST_ONLINE;
    assign offline_run_o = state_q == rss_pkg::ST_OFFLINE;
    assign irq_o         = |(err_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_abort_resp;
        ##1 selftest_abort_o && err_q.hw_abort ##0 state_q != rss_pkg::ST_ONLINE;
    endsequence

    property p_short_ext;
        (!wdg_exp && ext_act && short_sel && !por_act && !lvd_act && !dest_req_i)
            |=> state_q == rss_pkg::ST_PH3_FUNC;
    endproperty
    a_short_ext: assert property (p_short_ext) else $error("short ext reset misrouted");

    property p_long_ext;
        (!wdg_exp && ext_act && !short_sel) |=> state_q == rss_pkg::ST_PH1;
    endproperty
    a_long_ext: assert property (p_long_ext) else $error("long ext reset misrouted");

    property p_dest;
        (!wdg_exp && dest_req_i && !ent_ph1) |=> state_q == rss_pkg::ST_PH3_DEST;
    endproperty
    a_dest: assert property (p_dest) else $error("destructive entry wrong");

    property p_func;
        (!wdg_exp && func_req_i && !dest_req_i && !ent_ph1)
            |=> state_q == rss_pkg::ST_PH3_FUNC;
    endproperty
    a_func: assert property (p_func) else $error("functional entry wrong");

    property p_lvd;
        (!wdg_exp && lvd_act) |=> in_reset_o && state_q == rss_pkg::ST_PH1;
    endproperty
    a_lvd: assert property (p_lvd) else $error("lvd did not enter sequence");

    property p_wdg_exit;
        (busy && wdg_cnt_q >= wdg_q) |=> device_reset_o && state_q == rss_pkg::ST_RUN
            ##1 !device_reset_o;
    endproperty
    a_wdg_exit: assert property (p_wdg_exit) else $error("watchdog exit missing");

    property p_wdg_bound;
        busy |-> wdg_cnt_q <= wdg_q;
    endproperty
    a_wdg_bound: assert property (p_wdg_bound) else $error("wait exceeds end count");

    property p_abort;
        (online_run_o && !wdg_exp && func_req_i) |-> s_abort_resp;
    endproperty
    a_abort: assert property (p_abort) else $error("online abort not flagged");

    property p_timeout;
        (self_run && wdg_exp) |=> err_q.wdg_timeout && !self_run;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag not set");

    property p_abort_flag;
        $rose(selftest_abort_o) |-> err_q.hw_abort;
    endproperty
    a_abort_flag: assert property (p_abort_flag) else $error("abort flag missing");

    property p_pll;
        (online_run_o && ctrl_q[rss_pkg::RSS_CTRL_PLL_EN] && !pll_lock) |=> err_q.pll_unlock;
    endproperty
    a_pll: assert property (p_pll) else $error("pll unlock flag missing");

    property p_cfg_load;
        (cfg_load_i && !wr_wdg) |=> wdg_q == $past(cfg_wdg_value_i);
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("config interval not loaded");

endmodule

/* File: testbench/rss_sequencer_tb.sv */
`timescale 1ns/10ps
`define RSS_CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module rss_sequencer_tb;
    logic        clk_i, avs_waitrequest, por_n, ext_n, pll_ok;
    logic        rst_n_i = 1'b0, avs_read = 1'b0, avs_write = 1'b0, cfg_load_i = 1'b0;
    logic        dest_req_i = 1'b0, func_req_i = 1'b0, ext_press = 1'b0, pll_drop = 1'b0;
    logic        por_track = 1'b0, selftest_done_i = 1'b0;
    logic        device_reset_o, in_reset_o, online_run_o, offline_run_o, abort_o, irq_o;
    logic [2:0]  lvd, rail_low = 3'h0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, cfg_wdg_value_i = 32'h0, avs_readdata, rdv, v;
    int          mismatches = 0, total_checks = 0, n, k;
    integer      seed = 32'h8FF4;

    ////////////////////////////////////////////////////////////////////////////////
    rss_sequencer #(.WDG_CYCLES(32'h0000_0400), .PHASE_CYC(50)) i_rss_sequencer (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_read(avs_read), .avs_write(avs_write),
        .avs_address(avs_address), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .power_on_reset_in_n_i(por_n), .ext_reset_n_i(ext_n), .lvd_i(lvd),
        .pll_locked_i(pll_ok), .dest_req_i(dest_req_i), .func_req_i(func_req_i),
        .selftest_done_i(selftest_done_i), .cfg_load_i(cfg_load_i),
        .cfg_wdg_value_i(cfg_wdg_value_i),
        .device_reset_o(device_reset_o), .in_reset_o(in_reset_o),
        .online_run_o(online_run_o), .offline_run_o(offline_run_o),
        .selftest_abort_o(abort_o), .irq_o(irq_o));
    rss_supply_model i_rss_supply_model (
        .rail_low_i(rail_low), .por_track_i(por_track), .ext_press_i(ext_press),
        .online_busy_i(online_run_o), .pll_drop_i(pll_drop), .power_on_reset_in_n_o(por_n),
        .ext_reset_n_o(ext_n), .lvd_o(lvd), .pll_locked_o(pll_ok));

    ////////////////////////////////////////////////////////////////////////////////
    task test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= wd;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (avs_waitrequest === 1'b0) break;
        end
        rdv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 20) begin
            mismatches++;
            test_done();
        end
    endtask

    task rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `RSS_CHK(nm, e, rdv)
    endtask

    // dev=1 waits for the device reset pulse, dev=0 for the end of the sequence
    task wait_ev(input bit dev, output int c);
        for (c = 0; c < 3000; c++) begin
            @(negedge clk_i);
            if (dev ? device_reset_o === 1'b1 : in_reset_o === 1'b0) break;
        end
        if (c == 3000) begin
            mismatches++;
            test_done();
        end
    endtask

    function automatic logic [31:0] exp_state(input int kind);
        return (kind == 2) ? 32'hB : ((kind == 1 || kind == 3) ? 32'hC : 32'h9);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wait_ev(1'b0, n);
        rchk("ctrl", rss_pkg::RSS_OFS_CTRL, 32'h0);
        rchk("wdg", rss_pkg::RSS_OFS_WDG, 32'h400);
        rchk("err", rss_pkg::RSS_OFS_ERR, 32'h0);
        rchk("unmapped", 5'h14, 32'h0);
        repeat (4) begin
            v = $random(seed);
            bus(1'b1, rss_pkg::RSS_OFS_MASK, v);
            rchk("mask", rss_pkg::RSS_OFS_MASK, {29'h0, v[2:0]});
        end
        bus(1'b1, rss_pkg::RSS_OFS_MASK, 32'h7);
        v = $random(seed);
        @(posedge clk_i);
        cfg_wdg_value_i <= v;
        cfg_load_i <= 1'b1;
        @(posedge clk_i);
        cfg_load_i <= 1'b0;
        rchk("cfg interval", rss_pkg::RSS_OFS_WDG, v);
        bus(1'b1, rss_pkg::RSS_OFS_WDG, 32'h400);
        // entry points: long pin, short pin, destructive, functional, lvd, lvd with por
        for (k = 0; k < 6; k++) begin
            bus(1'b1, rss_pkg::RSS_OFS_CTRL, {31'h0, k == 1});
            ext_press <= (k < 2);
            dest_req_i <= (k == 2);
            func_req_i <= (k == 3);
            rail_low <= (k > 3) ? (3'h4 >> (k - 4)) : 3'h0;
            por_track <= (k == 5);
            repeat (6) @(posedge clk_i);
            rchk("entry", rss_pkg::RSS_OFS_STATE, exp_state(k));
            {ext_press, dest_req_i, func_req_i, por_track, rail_low} <= 7'h00;
            wait_ev(1'b0, n);
        end
        bus(1'b1, rss_pkg::RSS_OFS_CTRL, 32'h2);
        @(negedge clk_i);
        `RSS_CHK("online run", 1'b1, online_run_o)
        @(posedge clk_i);
        func_req_i <= 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        `RSS_CHK("abort pulse", 1'b1, abort_o)
        `RSS_CHK("irq set", 1'b1, irq_o)
        @(posedge clk_i);
        func_req_i <= 1'b0;
        rchk("abort flag", rss_pkg::RSS_OFS_ERR, 32'h1);
        bus(1'b1, rss_pkg::RSS_OFS_ERR, 32'h1);
        rchk("err clear", rss_pkg::RSS_OFS_ERR, 32'h0);
        `RSS_CHK("irq clear", 1'b0, irq_o)
        wait_ev(1'b0, n);
        // short interval so the watchdog ends online self-test with pll lost
        bus(1'b1, rss_pkg::RSS_OFS_WDG, 32'h64);
        pll_drop <= 1'b1;
        bus(1'b1, rss_pkg::RSS_OFS_CTRL, 32'h6);
        wait_ev(1'b1, n);
        `RSS_CHK("timeout span", 1'b1, n >= 95 && n <= 110)
        @(posedge clk_i);
        pll_drop <= 1'b0;
        rchk("timeout flags", rss_pkg::RSS_OFS_ERR, 32'h6);
        rchk("after expiry", rss_pkg::RSS_OFS_STATE, 32'h0);
        bus(1'b1, rss_pkg::RSS_OFS_ERR, 32'h7);
        // online self-test that completes on its own leaves no flag behind
        bus(1'b1, rss_pkg::RSS_OFS_CTRL, 32'h2);
        selftest_done_i <= 1'b1;
        @(posedge clk_i);
        selftest_done_i <= 1'b0;
        rchk("done exit", rss_pkg::RSS_OFS_STATE, 32'h0);
        // stuck rail without power-on reset: only the watchdog gets the device out
        bus(1'b1, rss_pkg::RSS_OFS_CTRL, 32'h8);
        rail_low <= 3'h1;
        wait_ev(1'b1, n);
        `RSS_CHK("stuck rail release", 1'b1, n < 300)
        // long interval: the sequence reaches offline self-test, which never ends
        bus(1'b1, rss_pkg::RSS_OFS_WDG, 32'h400);
        rail_low <= 3'h0;
        for (n = 0; n < 400 && offline_run_o !== 1'b1; n++) @(negedge clk_i);
        `RSS_CHK("offline entered", 1'b1, offline_run_o)
        wait_ev(1'b1, n);
        `RSS_CHK("offline left", 1'b0, offline_run_o)
        rchk("offline timeout", rss_pkg::RSS_OFS_ERR, 32'h2);
        test_done();
    end
endmodule

/* File: testbench/rss_supply_model.sv */
`timescale 1ns/10ps
module rss_supply_model (
    input  wire logic [2:0] rail_low_i,            // rails below range
    input  wire logic       por_track_i,           // supervisor follows the rails
    input  wire logic       ext_press_i,           // external reset wanted
    input  wire logic       online_busy_i,         // device runs online self-test
    input  wire logic       pll_drop_i,            // pll loses lock
    output logic            power_on_reset_in_n_o, // supervisor output, low active
    output logic            ext_reset_n_o,         // reset pin, low active
    output logic [2:0]      lvd_o,                 // detector levels
    output logic            pll_locked_o           // lock status
);
    // supervisor keeps power-on reset low while por_track_i is set and a rail is low
    assign power_on_reset_in_n_o = ~(por_track_i & (|rail_low_i));
    // a press is held back until online self-test has ended
    assign ext_reset_n_o         = ~(ext_press_i & ~online_busy_i);
    assign lvd_o                 = rail_low_i;
    assign pll_locked_o          = ~pll_drop_i;
endmodule
